/* File: rtl/ccs_regs.vh */
// Summary of operation
// - patch readout hides address, selects patch input
// - clear in address mode zeroes address, pointer home
// - addressed coefficient takes reference unless view
// - value keying routes display and keypad to data
// - value digits fill left to right
// - clear in value keying zeroes data register
// - apply drives device, indicator lit about 1s
// - setting done returns to address entry
// - apply disconnects input even in view mode
// - up/down slew servo pot, input kept
// - timer cycles initial, compute, hold intervals
// - interval time is count times unit
// - carry pulse at each interval change
// - speed buttons decode to four time scales
// - time scale picks logic clock sub-frequency
// - analog mode buttons affect analog only
// - load mode initialises logic components
// - run mode delivers logic clocks
// - stop mode withholds logic clocks
// - timer-driven modes override analog buttons
// - burst advance releases pulses only in stop
// - overload freeze forces hold on overload
// - address holds class, field, area, number
`ifndef CCS_REGS_VH
`define CCS_REGS_VH
`define CCS_ADDR_CTRL     12'h000
`define CCS_ADDR_MODE     12'h004
`define CCS_ADDR_TIMER    12'h008
`define CCS_ADDR_ADDRESS  12'h00c
`define CCS_ADDR_DATA     12'h010
`define CCS_ADDR_STATUS   12'h014
`define CCS_APPLY_MS      1000
`define CCS_CLK_MHZ       100
`define CCS_APPLY_CYC     (`CCS_APPLY_MS * 1000 * `CCS_CLK_MHZ)
`define CCS_UNIT_CYC      (`CCS_CLK_MHZ * 10000)
`define CCS_BURST_LEN     8'h08
`define CCS_DIV_X1        10'h3e7
`define CCS_DIV_X10       10'h063
`define CCS_DIV_SPEED_HUNDREDFOLD      10'h009
`define CCS_DIV_SPEED_THOUSANDFOLD     10'h000
`define CCS_KEY_DIGIT     2'h0
`define CCS_KEY_CLEAR     2'h1
`define CCS_KEY_APPLY     2'h2
`endif

/* File: rtl/ccs_top.v */
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
`include "ccs_regs.vh"
module ccs_top #(
  parameter APPLY_CYC = `CCS_APPLY_CYC,
  parameter UNIT_CYC  = `CCS_UNIT_CYC
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // analog side
  input  wire        overload,
  input  wire        servo_pot_addressed,
  output reg         readout_from_patch,
  output reg         address_display_blank,
  output reg         coef_input_reference,
  output reg         apply_coefficient,
  output reg         servo_up,
  output reg         servo_down,
  output reg  [1:0]  analog_mode_bus,
  output reg  [1:0]  time_scale,
  // logic side
  output reg         logic_clear,
  output reg         logic_clock,
  output reg         timer_carry
);
// ----------------------------------------------------------------
// software-visible control
// ----------------------------------------------------------------
reg  [7:0]  ctrl_q;
reg  [5:0]  mode_q;
reg  [31:0] timer_q;
reg  [15:0] address_q;
reg  [19:0] data_q;
reg  [2:0]  ptr_q;
reg         value_keying_q;
reg  [31:0] apply_cnt_q;
reg  [1:0]  interval_q;
reg  [31:0] unit_cnt_q;
reg  [7:0]  burst_q;
reg  [9:0]  div_q;
wire        patch_readout_select          = ctrl_q[0];
wire        coefficient_times_input_view  = ctrl_q[1];
wire        timer_driven_analog_modes     = ctrl_q[2];
wire        overload_freeze               = ctrl_q[3];
wire        speed_tenfold                 = ctrl_q[4];
wire        speed_hundredfold             = ctrl_q[5];
wire [1:0]  analog_buttons                = mode_q[1:0];
wire [1:0]  logic_buttons                 = mode_q[3:2];
wire        wr = psel && penable && pwrite && pready;
wire        key_wr = wr && (paddr == `CCS_ADDR_DATA);
wire [1:0]  key_kind = pwdata[5:4];
wire [3:0]  key_val  = pwdata[3:0];
wire        applying = (apply_cnt_q != 32'h0);
wire        mode_wr      = wr && (paddr == `CCS_ADDR_MODE);
wire        enter_keying = mode_wr && pwdata[6];
wire        burst_req    = mode_wr && pwdata[7];
// status fields, low bit kept spare
wire [31:0] status_word  = {24'h0,
                            burst_q != 8'h0,
                            applying,
                            value_keying_q,
                            interval_q,
                            analog_mode_bus,
                            1'b0};
// ----------------------------------------------------------------
// apb slave, one wait state
// ----------------------------------------------------------------
always @(posedge sys_clk) begin
  if (!reset_n) begin
    pready  <= 1'b0;
    pslverr <= 1'b0;
    prdata  <= 32'h0;
  end else begin
    pready  <= psel && penable && !pready;
    pslverr <= 1'b0;
    if (psel && penable && !pready) begin
      pslverr <= (paddr > `CCS_ADDR_STATUS) || (paddr[1:0] != 2'h0);
      case (paddr)
        `CCS_ADDR_CTRL:    prdata <= {24'h0, ctrl_q};
        `CCS_ADDR_MODE:    prdata <= {26'h0, mode_q};
        `CCS_ADDR_TIMER:   prdata <= timer_q;
        `CCS_ADDR_ADDRESS: prdata <= {13'h0, ptr_q, address_q};
        `CCS_ADDR_DATA:    prdata <= {12'h0, data_q};
        `CCS_ADDR_STATUS:  prdata <= status_word;
        default:           prdata <= 32'h0;
      endcase
    end
  end
end
// ----------------------------------------------------------------
// configuration registers
// ----------------------------------------------------------------
always @(posedge sys_clk) begin
  if (!reset_n) begin
    ctrl_q  <= 8'h0;
    mode_q  <= 6'h0;
    timer_q <= 32'h0;
  end else begin
    if (wr && paddr == `CCS_ADDR_CTRL)
      ctrl_q <= pwdata[7:0];
    // field write replaces previous selection
    if (mode_wr)
      mode_q <= pwdata[5:0];
    if (wr && paddr == `CCS_ADDR_TIMER)
      timer_q <= pwdata;
  end
end
// ----------------------------------------------------------------
// mode, address and data entry
// ----------------------------------------------------------------
always @(posedge sys_clk) begin
  if (!reset_n) begin
    address_q      <= 16'h0;
    data_q         <= 20'h0;
    ptr_q          <= 3'h0;
    value_keying_q <= 1'b0;
    apply_cnt_q    <= 32'h0;
  end else begin
    if (applying) begin
      apply_cnt_q <= apply_cnt_q - 32'h1;
      if (apply_cnt_q == 32'h1)
        value_keying_q <= 1'b0;
    end else if (key_wr) begin
      case (key_kind)
        `CCS_KEY_DIGIT: begin
          if (value_keying_q) begin
            case (ptr_q)
              3'h0: data_q[19:16] <= key_val;
              3'h1: data_q[15:12] <= key_val;
              3'h2: data_q[11:8]  <= key_val;
              3'h3: data_q[7:4]   <= key_val;
              3'h4: data_q[3:0]   <= key_val;
              default: data_q <= data_q;
            endcase
            if (ptr_q < 3'h5)
              ptr_q <= ptr_q + 3'h1;
          end else begin
            // class, field, area, number in entry order
            case (ptr_q)
              3'h0: address_q[15:12] <= key_val;
              3'h1: address_q[11:8]  <= key_val;
              3'h2: address_q[7:4]   <= key_val;
              3'h3: address_q[3:0]   <= key_val;
              default: address_q <= address_q;
            endcase
            if (ptr_q < 3'h4)
              ptr_q <= ptr_q + 3'h1;
          end
        end
        `CCS_KEY_CLEAR: begin
          ptr_q <= 3'h0;
          if (value_keying_q)
            data_q <= 20'h0;
          else
            address_q <= 16'h0;
        end
        `CCS_KEY_APPLY: begin
          if (value_keying_q) begin
            apply_cnt_q <= APPLY_CYC;
            ptr_q       <= 3'h0;
          end
        end
        default: ptr_q <= ptr_q;
      endcase
    end
    // placed last so a request in the final apply cycle wins
    if (enter_keying) begin
      value_keying_q <= 1'b1;
      // pointer left over from address entry would skip digits
      ptr_q          <= 3'h0;
    end
  end
end
// ----------------------------------------------------------------
// readout and coefficient connection
// ----------------------------------------------------------------
always @(posedge sys_clk) begin
  if (!reset_n) begin
    readout_from_patch    <= 1'b0;
    address_display_blank <= 1'b0;
    coef_input_reference  <= 1'b0;
    apply_coefficient     <= 1'b0;
    servo_up              <= 1'b0;
    servo_down            <= 1'b0;
  end else begin
    readout_from_patch    <= patch_readout_select;
    address_display_blank <= patch_readout_select;
    // apply overrides the view so setting sees reference
    coef_input_reference  <= applying || !coefficient_times_input_view;
    apply_coefficient     <= applying;
    // slewing leaves input connection alone
    servo_up   <= servo_pot_addressed && ctrl_q[6] && !applying;
    servo_down <= servo_pot_addressed && ctrl_q[7] && !applying;
  end
end
// ----------------------------------------------------------------
// time scale and clock sub-frequency
// ----------------------------------------------------------------
reg  [9:0] div_max;
always @* begin
  case (time_scale)
    2'h0:    div_max = `CCS_DIV_X1;
    2'h1:    div_max = `CCS_DIV_X10;
    2'h2:    div_max = `CCS_DIV_SPEED_HUNDREDFOLD;
    default: div_max = `CCS_DIV_SPEED_THOUSANDFOLD;
  endcase
end
// one divider feeds timer and logic so both scale together
wire       sub_tick = (div_q == div_max);
always @(posedge sys_clk) begin
  if (!reset_n) begin
    time_scale <= 2'h0;
    div_q      <= 10'h0;
  end else begin
    // hundredfold is the high bit, tenfold the low bit
    time_scale <= {speed_hundredfold, speed_tenfold};
    div_q      <= sub_tick ? 10'h0 : div_q + 10'h1;
  end
end
// ----------------------------------------------------------------
// interval timer
// ----------------------------------------------------------------
reg  [7:0]  cur_count;
reg  [1:0]  cur_unit;
reg  [6:0]  unit_mult;
always @* begin
  case (interval_q)
    2'h0: begin
      cur_count = timer_q[7:0];
      cur_unit  = timer_q[25:24];
    end
    2'h1: begin
      cur_count = timer_q[15:8];
      cur_unit  = timer_q[27:26];
    end
    default: begin
      cur_count = timer_q[23:16];
      cur_unit  = timer_q[29:28];
    end
  endcase
end
// unit tick is the finest step, coarser units count it up
always @* begin
  case (cur_unit)
    2'h0:    unit_mult = 7'h64;
    2'h1:    unit_mult = 7'h0a;
    default: unit_mult = 7'h01;
  endcase
end
wire [6:0]  cur_ticks = {3'h0, cur_count[7:4]} * 7'h0a + {3'h0, cur_count[3:0]};
wire        unit_tick = sub_tick && (unit_cnt_q >= UNIT_CYC / 1000 - 1);
reg  [13:0] sub_cnt_q;
wire [13:0] interval_len = cur_ticks * unit_mult;
always @(posedge sys_clk) begin
  if (!reset_n) begin
    interval_q  <= 2'h0;
    unit_cnt_q  <= 32'h0;
    sub_cnt_q   <= 14'h0;
    timer_carry <= 1'b0;
  end else begin
    timer_carry <= 1'b0;
    if (sub_tick)
      unit_cnt_q <= unit_tick ? 32'h0 : unit_cnt_q + 32'h1;
    if (unit_tick) begin
      if (sub_cnt_q + 14'h1 >= interval_len) begin
        sub_cnt_q   <= 14'h0;
        interval_q  <= (interval_q == 2'h2) ? 2'h0 : interval_q + 2'h1;
        timer_carry <= 1'b1;
      end else
        sub_cnt_q <= sub_cnt_q + 14'h1;
    end
  end
end
// ----------------------------------------------------------------
// analog modes: 0 initial, 1 compute, 2 hold
// ----------------------------------------------------------------
// the spare button code is taken as hold, the safe choice
reg  [1:0] analog_sel;
always @* begin
  case (analog_buttons)
    2'h1:    analog_sel = 2'h1;
    2'h2:    analog_sel = 2'h2;
    2'h3:    analog_sel = 2'h2;
    default: analog_sel = 2'h0;
  endcase
end
always @(posedge sys_clk) begin
  if (!reset_n)
    analog_mode_bus <= 2'h0;
  else if (overload_freeze && overload)
    analog_mode_bus <= 2'h2;
  else if (timer_driven_analog_modes)
    analog_mode_bus <= interval_q;
  else
    analog_mode_bus <= analog_sel;
end
// ----------------------------------------------------------------
// logic modes: 0 load, 1 run, 2 stop
// ----------------------------------------------------------------
always @(posedge sys_clk) begin
  if (!reset_n) begin
    logic_clear <= 1'b1;
    logic_clock <= 1'b0;
    burst_q     <= 8'h0;
  end else begin
    logic_clear <= (logic_buttons == 2'h0);
    logic_clock <= 1'b0;
    case (logic_buttons)
      2'h1: begin
        logic_clock <= sub_tick;
        burst_q     <= 8'h0;
      end
      2'h2: begin
        if (burst_req && burst_q == 8'h0)
          burst_q <= `CCS_BURST_LEN;
        else if (burst_q != 8'h0 && sub_tick) begin
          logic_clock <= 1'b1;
          burst_q     <= burst_q - 8'h1;
        end
      end
      default: burst_q <= 8'h0;
    endcase
  end
end
endmodule // ccs_top

/* File: test/ccs_operator.sv */
`timescale 1ns/10ps
module ccs_operator (
  // clock
  input  wire  sys_clk,
  // scripted operator actions
  input  wire  ovl_cmd,
  input  wire  pot_cmd,
  // toward the console
  output logic overload            = 1'b0,
  output logic servo_pot_addressed = 1'b0
);
  // actions land just after an edge, never mid-cycle
  always @(posedge sys_clk) begin
    overload            <= ovl_cmd;
    servo_pot_addressed <= pot_cmd;
  end
endmodule // ccs_operator

/* File: test/ccs_properties.sv */
`timescale 1ns/10ps
module ccs_checker (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // watched ports
  input wire pready,
  input wire servo_pot_addressed,
  input wire readout_from_patch,
  input wire address_display_blank,
  input wire coef_input_reference,
  input wire apply_coefficient,
  input wire servo_up,
  input wire servo_down,
  input wire logic_clear,
  input wire logic_clock,
  input wire timer_carry
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence apply_start_s;
    $rose(apply_coefficient);
  endsequence
  sequence apply_hold_s;
    apply_coefficient [*8];
  endsequence
  blank_follows_patch_a: assert property (address_display_blank == readout_from_patch)
    else $error("display blanking differs from patch readout");
  apply_on_reference_a: assert property (apply_coefficient |-> coef_input_reference)
    else $error("input not on reference while applying");
  apply_stays_lit_a: assert property (apply_start_s |-> apply_hold_s)
    else $error("apply indicator dropped early");
  servo_needs_pot_a: assert property ((servo_up || servo_down) |-> $past(servo_pot_addressed))
    else $error("servo slew without a servo pot");
  servo_not_applying_a: assert property (servo_up |-> !apply_coefficient)
    else $error("servo slew during apply");
  carry_single_pulse_a: assert property (timer_carry |=> !timer_carry)
    else $error("carry longer than one cycle");
  load_no_clock_a: assert property (logic_clear |-> !logic_clock)
    else $error("logic clock in load mode");
  load_after_reset_a: assert property ($rose(reset_n) |-> logic_clear)
    else $error("not in load after reset");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
endmodule // ccs_checker

bind ccs_top ccs_checker ccs_checker_i (.sys_clk(sys_clk), .reset_n(reset_n), .pready(pready),
  .servo_pot_addressed(servo_pot_addressed), .readout_from_patch(readout_from_patch),
  .address_display_blank(address_display_blank), .coef_input_reference(coef_input_reference),
  .apply_coefficient(apply_coefficient), .servo_up(servo_up), .servo_down(servo_down),
  .logic_clear(logic_clear), .logic_clock(logic_clock), .timer_carry(timer_carry));

/* File: test/console_control_sequencer_tb_top.sv */
`timescale 1ns/10ps
`include "ccs_regs.vh"
module console_control_sequencer_tb_top;
  logic        sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        ovl_cmd = 0, pot_cmd = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, ovl, pot, rdp, adb, cir, apc, sup, sdn, lcl, lck, tcy;
  wire  [1:0]  amb, tsc;
  int          mismatches = 0, comparisons = 0, cyc = 0, n, prev;
  logic [7:0]  ctl [8] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20, 8'h30, 8'h40, 8'h80};
  logic [6:0]  exo [8] = '{7'h10, 7'h1c, 7'h00, 7'h11, 7'h12, 7'h13, 7'h50, 7'h30};

  ccs_top #(.APPLY_CYC(20), .UNIT_CYC(2000)) ccs_top_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .overload(ovl),
    .servo_pot_addressed(pot), .readout_from_patch(rdp), .address_display_blank(adb),
    .coef_input_reference(cir), .apply_coefficient(apc), .servo_up(sup), .servo_down(sdn),
    .analog_mode_bus(amb), .time_scale(tsc), .logic_clear(lcl), .logic_clock(lck),
    .timer_carry(tcy));
  ccs_operator ccs_operator_i (.sys_clk(sys_clk), .ovl_cmd(ovl_cmd), .pot_cmd(pot_cmd),
    .overload(ovl), .servo_pot_addressed(pot));

  always #5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task key(input logic [1:0] k, input logic [3:0] d);
    apb(1'b1, `CCS_ADDR_DATA, {26'h0, k, d});
  endtask
  task clocks(input int len, output int c);
    c = 0;
    repeat (len) begin
      @(posedge sys_clk);
      if (lck === 1'b1) c++;
    end
  endtask
  task do_reset;
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask
  task test_done;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, generous over the longest timer wait
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      test_done;
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    do_reset;
    chk({lcl, tsc, apc}, 4'b1000);
    pot_cmd <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `CCS_ADDR_CTRL, {24'h0, ctl[i]});
      repeat (2) @(posedge sys_clk);
      chk({sup, sdn, cir, adb, rdp, tsc}, exo[i]);
    end
    key(`CCS_KEY_DIGIT, 4'h5);
    key(`CCS_KEY_DIGIT, 4'h3);
    apb(1'b0, `CCS_ADDR_ADDRESS, 32'h0);
    chk(rd, 32'h0002_5300);
    key(`CCS_KEY_CLEAR, 4'h0);
    apb(1'b0, `CCS_ADDR_ADDRESS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `CCS_ADDR_MODE, 32'h40);
    key(`CCS_KEY_DIGIT, 4'h1);
    key(`CCS_KEY_DIGIT, 4'h2);
    apb(1'b0, `CCS_ADDR_DATA, 32'h0);
    chk(rd, 32'h0001_2000);
    apb(1'b0, `CCS_ADDR_ADDRESS, 32'h0);
    chk(rd, 32'h0002_0000);
    key(`CCS_KEY_CLEAR, 4'h0);
    apb(1'b0, `CCS_ADDR_DATA, 32'h0);
    chk(rd, 32'h0);
    key(`CCS_KEY_DIGIT, 4'h7);
    apb(1'b1, `CCS_ADDR_CTRL, 32'h02);
    key(`CCS_KEY_APPLY, 4'h0);
    n = 0;
    while (apc !== 1'b1 && n < 10) begin
      @(posedge sys_clk);
      n++;
    end
    chk(apc, 1'b1);
    chk(cir, 1'b1);
    n = 0;
    while (apc === 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n >= 19 && n <= 21, 1'b1);
    apb(1'b0, `CCS_ADDR_STATUS, 32'h0);
    chk({rd[6:5], cir}, 3'b000);
    apb(1'b1, `CCS_ADDR_MODE, 32'h05);
    clocks(2000, n);
    chk({amb, lcl, n > 0}, 4'b0101);
    apb(1'b1, `CCS_ADDR_MODE, 32'h09);
    clocks(2000, n);
    chk(n, 0);
    apb(1'b1, `CCS_ADDR_MODE, 32'h89);
    clocks(9000, n);
    chk(n, 8);
    apb(1'b1, `CCS_ADDR_MODE, 32'h01);
    repeat (2) @(posedge sys_clk);
    chk({amb, lcl}, 3'b011);
    apb(1'b1, `CCS_ADDR_CTRL, 32'h08);
    ovl_cmd <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(amb, 2'h2);
    ovl_cmd <= 1'b0;
    apb(1'b1, `CCS_ADDR_TIMER, 32'h2a01_0101);
    apb(1'b1, `CCS_ADDR_CTRL, 32'h04);
    prev = 3;
    repeat (4) begin
      n = 0;
      while (tcy !== 1'b1 && n < 15000) begin
        @(posedge sys_clk);
        n++;
      end
      chk(n < 15000, 1'b1);
      repeat (2) @(posedge sys_clk);
      if (prev != 3) chk(amb, (prev + 1) % 3);
      prev = amb;
    end
    apb(1'b0, 12'h018, 32'h0);
    chk(err, 1'b1);
    do_reset;
    chk({lcl, tsc, amb}, 5'b10000);
    test_done;
  end
endmodule // console_control_sequencer_tb_top
